// file: hw/gpio_master_map.svh
// Constant map of the I2C/SPI master bridge: buffer layout, control codes,
// per-group cycle positions and watchdog timing.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef GPIO_MASTER_MAP_SVH
`define GPIO_MASTER_MAP_SVH

// ----------------------------------------------------------------------
// Buffer layout
// ----------------------------------------------------------------------
`define MB_BYTES           6
`define MB_LAST_GROUP      2'h2
`define MB_RESET_BYTE      8'hff
`define MB_MODE_BIT        3

// ----------------------------------------------------------------------
// I2C write codes and readback codes
// ----------------------------------------------------------------------
`define I2C_PRE_START      4'h6
`define I2C_PRE_STOP       4'h1
`define I2C_PRE_BLANK      4'h0
`define I2C_PRE_NOTX       4'h7
`define I2C_POST_ACK       4'h0
`define I2C_POST_NACK_STOP 4'h9
`define I2C_RB_SDA_HIGH    4'h7
`define I2C_RB_MASTER_ACK  4'h0
`define I2C_RB_SLAVE_ACK   4'h7
`define I2C_RB_SLAVE_NACK  4'hf
`define I2C_RB_ACK_STOP    4'h1
`define I2C_RB_NACK_STOP   4'h9

// ----------------------------------------------------------------------
// SPI write codes and readback codes
// ----------------------------------------------------------------------
`define SPI_PRE_LOW        4'h8
`define SPI_PRE_EDGE       4'ha
`define SPI_PRE_HIGH       4'h9
`define SPI_PRE_NOTX       4'hf
`define SPI_POST_HIGH      4'h9
`define SPI_RB_PRE         4'h7
`define SPI_RB_POST        4'hf

// ----------------------------------------------------------------------
// Link-clock positions inside one 24-cycle group
// ----------------------------------------------------------------------
`define CYC_PRE_A          5'd0
`define CYC_PRE_B          5'd1
`define CYC_PRE_C          5'd2
`define CYC_FIRST_BIT      5'd3
`define CYC_LAST_BIT_HIGH  5'd18
`define CYC_ACK_LOW        5'd19
`define CYC_ACK_HIGH       5'd20
`define CYC_STOP_LOW       5'd21
`define CYC_STOP_SCL       5'd22
`define CYC_END            5'd23
`define CYC_FIRST_CAP      5'd7
`define CYC_LAST_CAP       5'd21

// ----------------------------------------------------------------------
// Watchdog timing
// ----------------------------------------------------------------------
`define WDOG_TIME_MS       2000
`define CLK_FREQ_KHZ       100000
`define WDOG_CYCLES        (`WDOG_TIME_MS * `CLK_FREQ_KHZ)

`endif

// file: hw/gpio_master_pkg.sv
// Types shared by the I2C/SPI master bridge and its command decoder.
// Assumes the command decoder of the primary serial port uses cmd_e.
package gpio_master_pkg;

  // ----------------------------------------------------------------------
  // Buffer commands as decoded from the primary serial port
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_NONE,
    CMD_WRITE_BUF,
    CMD_START_XFER,
    CMD_READ_BUF
  } cmd_e;

endpackage

// file: hw/gpio_i2c_spi_master_bridge.sv
// I2C/SPI master bridge on three open-drain I/O lines, paced by the
// primary serial clock. Assumes an upstream decoder on the link clock that
// delivers commands, write bytes and the write check result.
`include "gpio_master_map.svh"
`timescale 1ns/1ps
`default_nettype none

module gpio_i2c_spi_master_bridge #(
  parameter int WDOG_CYCLES = `WDOG_CYCLES  // Shorten in simulation
) (
  input  wire logic                  clock_in,            // Core clock
  input  wire logic                  rstn_in,             // Sync reset, low
  input  wire logic                  clock_en_in,         // Core freeze when low
  input  wire logic                  thermal_shutdown_in, // Core-domain event
  input  wire logic                  link_clock_in,       // Primary serial clock
  input  wire logic                  link_frame_in,       // Host frame, high while active
  input  wire logic                  cmd_valid_in,        // Command accepted
  input  wire gpio_master_pkg::cmd_e cmd_in,              // Which command
  input  wire logic                  wr_valid_in,         // Write byte strobe
  input  wire logic [7:0]            wr_data_in,          // Write byte
  input  wire logic                  wr_pec_fail_in,      // Write check failed
  input  wire logic [2:0]            rd_index_in,         // Byte to read back
  output logic      [7:0]            rd_data_out,         // Read-back byte
  output logic                       xfer_busy_out,       // Transfer running
  input  wire logic                  io_line_three_in,    // Data line level
  output logic                       io_line_two_out,     // Always low
  output logic                       io_line_two_oe_n_out,
  output logic                       io_line_three_out,   // Always low
  output logic                       io_line_three_oe_n_out,
  output logic                       io_line_four_out,    // Always low
  output logic                       io_line_four_oe_n_out
);

  // ----------------------------------------------------------------------
  // Core domain: watchdog, reset request, pin output stage
  // ----------------------------------------------------------------------
  logic [31:0] wd_cnt_q;      // Watchdog count
  logic        wd_fire_w;     // Watchdog expiry
  logic        act_s1_q;      // Activity toggle sync, first stage
  logic        act_s2_q;      // Activity toggle sync, second stage
  logic        act_s3_q;      // Edge detect delay
  logic        req_q;         // Link reset request level
  logic        ack_s1_q;      // Link acknowledge sync
  logic        ack_s2_q;
  logic [2:0]  lvl_s1_q;      // Pin level sync into core
  logic [2:0]  lvl_s2_q;
  logic [2:0]  oe_n_q;        // Registered open-drain enables
  logic        drive_q;       // Open drain only ever pulls low

  // ----------------------------------------------------------------------
  // Link domain state
  // ----------------------------------------------------------------------
  logic [7:0]  buf_q [`MB_BYTES];  // Master buffer
  logic [2:0]  wr_ptr_q;      // Next write slot
  logic        xfer_q;        // Transfer in progress
  logic [4:0]  cyc_q;         // Cycle inside group
  logic [1:0]  grp_q;         // Group index
  logic        ign_q;         // Rest of group ignored
  logic        sda_mid_q;     // Data level seen between bytes
  logic [7:0]  rx_q;          // Received byte
  logic [2:0]  lvl_q;         // {clock, data, select}, 1 = released
  logic [2:0]  lvl_d;
  logic        act_q;         // Toggles on each command
  logic        lreq_s1_q;     // Reset request sync into link
  logic        lreq_s2_q;
  logic        din_s1_q;      // Data pin sync into link
  logic        din_s2_q;
  logic [7:0]  rd_q;          // Read-back register
  logic        lrst_w;        // Link-side reset

  // Current group fields
  logic [2:0]  lo_idx_w;
  logic [2:0]  hi_idx_w;
  logic [3:0]  pre_w;
  logic [3:0]  post_w;
  logic [7:0]  data_w;
  logic        spi_w;         // Group runs as SPI master
  logic        ign_w;         // Group ignored from this cycle
  logic [4:0]  boff_w;        // Offset from first bit cycle
  logic        bit_lo_w;      // Clock low, data set
  logic        bit_hi_w;      // Clock high
  logic        cap_w;         // Capture a received bit
  logic        run_w;         // Link active this edge
  logic        stop_w;        // I2C post code asks for STOP

  assign wd_fire_w = (wd_cnt_q == 32'(WDOG_CYCLES - 1));

  // Watchdog restarted by any command from the host
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      wd_cnt_q <= 32'h0;
    end else if (clock_en_in) begin
      if (act_s2_q ^ act_s3_q) begin
        wd_cnt_q <= 32'h0;
      end else if (wd_fire_w) begin
        wd_cnt_q <= 32'h0;
      end else begin
        wd_cnt_q <= wd_cnt_q + 32'h1;
      end
    end
  end

  // Crossing flops from the link domain
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      act_s1_q <= 1'b0;
      act_s2_q <= 1'b0;
      act_s3_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      lvl_s1_q <= 3'h7;
      lvl_s2_q <= 3'h7;
    end else if (clock_en_in) begin
      act_s1_q <= act_q;
      act_s2_q <= act_s1_q;
      act_s3_q <= act_s2_q;
      ack_s1_q <= lreq_s2_q;
      ack_s2_q <= ack_s1_q;
      lvl_s1_q <= lvl_q;
      lvl_s2_q <= lvl_s1_q;
    end
  end

  // Four-phase request: held until the link side echoes it back
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      req_q <= 1'b1;                   // Link is cleared after core reset
    end else if (clock_en_in) begin
      if ((wd_fire_w || thermal_shutdown_in) && !ack_s2_q) begin
        req_q <= 1'b1;                 // Timeout or overheat
      end else if (ack_s2_q) begin
        req_q <= 1'b0;
      end
    end
  end

  // Pins released at once on a pending reset, so a stopped link clock
  // cannot keep a line pulled low
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      oe_n_q  <= 3'h7;
      drive_q <= 1'b0;
    end else if (clock_en_in) begin
      oe_n_q  <= req_q ? 3'h7 : lvl_s2_q;
      drive_q <= 1'b0;
    end
  end

  // Line two select, three data, four clock
  assign io_line_two_out        = drive_q;
  assign io_line_three_out      = drive_q;
  assign io_line_four_out       = drive_q;
  assign io_line_two_oe_n_out   = oe_n_q[0];
  assign io_line_three_oe_n_out = oe_n_q[1];
  assign io_line_four_oe_n_out  = oe_n_q[2];

  // ----------------------------------------------------------------------
  // Link domain: synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge link_clock_in) begin
    lreq_s1_q <= req_q;
    lreq_s2_q <= lreq_s1_q;
    din_s1_q  <= io_line_three_in;
    din_s2_q  <= din_s1_q;
  end

  assign lrst_w = lreq_s2_q;
  assign run_w  = xfer_q && link_frame_in;

  // ----------------------------------------------------------------------
  // Group decode
  // ----------------------------------------------------------------------
  assign lo_idx_w = {grp_q, 1'b0};
  assign hi_idx_w = {grp_q, 1'b1};
  assign pre_w    = buf_q[lo_idx_w][7:4];
  assign post_w   = buf_q[hi_idx_w][3:0];
  assign data_w   = {buf_q[lo_idx_w][3:0], buf_q[hi_idx_w][7:4]};
  assign spi_w    = pre_w[`MB_MODE_BIT];
  assign stop_w   = (post_w == `I2C_POST_NACK_STOP);
  assign boff_w   = cyc_q - `CYC_FIRST_BIT;
  assign bit_lo_w = (cyc_q >= `CYC_FIRST_BIT) && (cyc_q < `CYC_LAST_BIT_HIGH)
                    && cyc_q[0];
  assign bit_hi_w = (cyc_q > `CYC_FIRST_BIT) && (cyc_q <= `CYC_LAST_BIT_HIGH)
                    && !cyc_q[0];
  assign cap_w    = (cyc_q >= `CYC_FIRST_CAP) && (cyc_q <= `CYC_LAST_CAP)
                    && cyc_q[0];

  // Stop, release and select-high codes end the group at once
  assign ign_w = (cyc_q == `CYC_PRE_A) ?
                 (spi_w ? (pre_w == `SPI_PRE_HIGH || pre_w == `SPI_PRE_NOTX)
                        : (pre_w == `I2C_PRE_STOP || pre_w == `I2C_PRE_NOTX))
                 : ign_q;

  // ----------------------------------------------------------------------
  // Pin level sequencing, one master period per two link clocks
  // ----------------------------------------------------------------------
  always_comb begin
    lvl_d = lvl_q;
    if (run_w) begin
      if (!spi_w) begin
        // I2C pre-byte actions
        if (pre_w == `I2C_PRE_START) begin
          if (cyc_q == `CYC_PRE_A) lvl_d[1] = 1'b1;
          if (cyc_q == `CYC_PRE_B) lvl_d[2] = 1'b1;
          if (cyc_q == `CYC_PRE_C) lvl_d[1] = 1'b0;   // Start condition
        end else if (pre_w == `I2C_PRE_STOP) begin
          if (cyc_q == `CYC_PRE_A) lvl_d[1] = 1'b0;
          if (cyc_q == `CYC_PRE_B) lvl_d[2] = 1'b1;
          if (cyc_q == `CYC_PRE_C) lvl_d[1] = 1'b1;   // Lines left high
        end else if (pre_w == `I2C_PRE_NOTX && cyc_q == `CYC_PRE_A) begin
          lvl_d[2:1] = 2'h3;                          // Both released
        end
      end else if (cyc_q == `CYC_PRE_A) begin
        // SPI pre-byte actions
        if (pre_w == `SPI_PRE_LOW) begin
          lvl_d[0] = 1'b0;
        end else if (pre_w == `SPI_PRE_EDGE) begin
          lvl_d[0] = 1'b1;
        end else if (ign_w) begin
          lvl_d = 3'h7;                               // Release all
        end
      end else if (cyc_q == `CYC_PRE_B && pre_w == `SPI_PRE_EDGE) begin
        lvl_d[0] = 1'b0;                              // Falling edge
      end
      if (!ign_w) begin
        if (bit_lo_w) begin
          lvl_d[2] = 1'b0;
          lvl_d[1] = data_w[~boff_w[3:1]];            // MSB first
        end else if (bit_hi_w) begin
          lvl_d[2] = 1'b1;                            // Sample edge
        end else if (!spi_w) begin
          // Ninth clock, then optional STOP
          if (cyc_q == `CYC_ACK_LOW) begin
            lvl_d[2] = 1'b0;
            lvl_d[1] = (post_w != `I2C_POST_ACK);
          end
          if (cyc_q == `CYC_ACK_HIGH) lvl_d[2] = 1'b1;
          if (cyc_q == `CYC_STOP_LOW) begin
            lvl_d[2] = 1'b0;
            if (stop_w) lvl_d[1] = 1'b0;
          end
          if (cyc_q == `CYC_STOP_SCL && stop_w) lvl_d[2] = 1'b1;
          if (cyc_q == `CYC_END && stop_w) lvl_d[1] = 1'b1;
        end else begin
          // SPI data released after the byte, select per post code
          if (cyc_q == `CYC_ACK_LOW) lvl_d[1] = 1'b1;
          if (cyc_q == `CYC_END && post_w == `SPI_POST_HIGH) lvl_d[0] = 1'b1;
        end
      end
    end
  end

  // Pin levels persist between transfers until a reset request
  always_ff @(posedge link_clock_in) begin
    if (lrst_w) begin
      lvl_q <= 3'h7;
    end else begin
      lvl_q <= lvl_d;
    end
  end

  // ----------------------------------------------------------------------
  // Transfer sequencing: 24 link clocks per group
  // ----------------------------------------------------------------------
  always_ff @(posedge link_clock_in) begin
    if (lrst_w) begin
      xfer_q <= 1'b0;
      cyc_q  <= 5'h0;
      grp_q  <= 2'h0;
      ign_q  <= 1'b0;
    end else if (cmd_valid_in && cmd_in == gpio_master_pkg::CMD_START_XFER) begin
      xfer_q <= 1'b1;
      cyc_q  <= 5'h0;
      grp_q  <= 2'h0;
      ign_q  <= 1'b0;
    end else if (!link_frame_in) begin
      xfer_q <= 1'b0;                                 // Host ended early
    end else if (xfer_q) begin
      ign_q <= ign_w;
      if (cyc_q == `CYC_END) begin
        cyc_q <= 5'h0;
        ign_q <= 1'b0;
        grp_q <= grp_q + 2'h1;
        if (grp_q == `MB_LAST_GROUP) xfer_q <= 1'b0;
      end else begin
        cyc_q <= cyc_q + 5'h1;
      end
    end
  end

  // Received data and mid-stream data level
  always_ff @(posedge link_clock_in) begin
    if (lrst_w) begin
      rx_q      <= 8'h0;
      sda_mid_q <= 1'b1;
    end else if (run_w) begin
      if (cap_w) rx_q <= {rx_q[6:0], din_s2_q};      // MSB first
      if (cyc_q == `CYC_PRE_C) sda_mid_q <= din_s2_q;
    end
  end

  // ----------------------------------------------------------------------
  // Buffer writes, check failure, readback at the end of each non-ignored group
  // ----------------------------------------------------------------------
  always_ff @(posedge link_clock_in) begin
    if (lrst_w) begin
      for (int i = 0; i < `MB_BYTES; i++) buf_q[i] <= `MB_RESET_BYTE;
      wr_ptr_q <= 3'h0;
    end else if (wr_pec_fail_in) begin
      for (int i = 0; i < `MB_BYTES; i++) buf_q[i] <= `MB_RESET_BYTE;
    end else if (cmd_valid_in && cmd_in == gpio_master_pkg::CMD_WRITE_BUF) begin
      wr_ptr_q <= 3'h0;
    end else if (wr_valid_in) begin
      if (wr_ptr_q < 3'(`MB_BYTES)) begin
        buf_q[wr_ptr_q] <= wr_data_in;
        wr_ptr_q        <= wr_ptr_q + 3'h1;
      end
    end else if (run_w && cyc_q == `CYC_END && !ign_q) begin
      // Ignored groups keep their contents untouched
      if (spi_w) begin
        buf_q[lo_idx_w] <= {`SPI_RB_PRE, rx_q[7:4]};
        buf_q[hi_idx_w] <= {rx_q[3:0], `SPI_RB_POST};
      end else begin
        buf_q[lo_idx_w][3:0] <= rx_q[7:4];
        buf_q[hi_idx_w][7:4] <= rx_q[3:0];
        if (pre_w != `I2C_PRE_START) begin
          buf_q[lo_idx_w][7:4] <= sda_mid_q ? `I2C_RB_SDA_HIGH : `I2C_PRE_BLANK;
        end
        if (post_w == `I2C_POST_ACK) begin
          buf_q[hi_idx_w][3:0] <= `I2C_RB_MASTER_ACK;
        end else if (din_s2_q) begin
          buf_q[hi_idx_w][3:0] <= stop_w ? `I2C_RB_NACK_STOP : `I2C_RB_SLAVE_NACK;
        end else begin
          buf_q[hi_idx_w][3:0] <= stop_w ? `I2C_RB_ACK_STOP : `I2C_RB_SLAVE_ACK;
        end
      end
    end
  end

  // Read port and activity toggle
  always_ff @(posedge link_clock_in) begin
    if (lrst_w) begin
      rd_q  <= `MB_RESET_BYTE;
      act_q <= 1'b0;
    end else begin
      rd_q <= (rd_index_in < 3'(`MB_BYTES)) ? buf_q[rd_index_in]
                                            : `MB_RESET_BYTE;
      if (cmd_valid_in) act_q <= ~act_q;
    end
  end

  assign rd_data_out   = rd_q;
  assign xfer_busy_out = xfer_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence clk_pulse_s;
    !lvl_q[2] ##1 lvl_q[2];
  endsequence

  sequence start_cond_s;
    lvl_q[2] && lvl_q[1] ##1 lvl_q[2] && !lvl_q[1];
  endsequence

  property bit_clock_p;
    @(posedge link_clock_in) disable iff (lrst_w)
    (run_w && !ign_w && cyc_q == `CYC_FIRST_BIT) |=> clk_pulse_s;
  endproperty

  i2c_start_seq_a: assert property (@(posedge link_clock_in) disable iff (lrst_w)
    (run_w && !spi_w && pre_w == `I2C_PRE_START && cyc_q == `CYC_PRE_B)
    |=> start_cond_s) else $error("start condition not generated");

  bit_period_a: assert property (bit_clock_p)
    else $error("master clock period wrong");

  spi_mode_a: assert property (@(posedge link_clock_in) disable iff (lrst_w)
    (run_w && spi_w && !ign_w && cyc_q == `CYC_LAST_BIT_HIGH) |=> lvl_q[2])
    else $error("spi clock not idle high");

  master_ack_a: assert property (@(posedge link_clock_in) disable iff (lrst_w)
    (run_w && !spi_w && !ign_w && cyc_q == `CYC_ACK_LOW && post_w == `I2C_POST_ACK)
    |=> !lvl_q[1] && !lvl_q[2] ##1 !lvl_q[1] && lvl_q[2])
    else $error("master ack missing");

  notx_release_a: assert property (@(posedge link_clock_in) disable iff (lrst_w)
    (run_w && cyc_q == `CYC_PRE_A && spi_w && pre_w == `SPI_PRE_NOTX)
    |=> lvl_q == 3'h7) else $error("spi lines not released");

  cs_raise_a: assert property (@(posedge link_clock_in) disable iff (lrst_w)
    (run_w && spi_w && !ign_w && cyc_q == `CYC_END && post_w == `SPI_POST_HIGH)
    |=> lvl_q[0]) else $error("select not raised");

  pec_fill_a: assert property (@(posedge link_clock_in) disable iff (lrst_w)
    wr_pec_fail_in |=> buf_q[0] == `MB_RESET_BYTE && buf_q[5] == `MB_RESET_BYTE)
    else $error("buffer not filled on bad check");

  spi_rb_a: assert property (@(posedge link_clock_in) disable iff (lrst_w)
    (run_w && spi_w && !ign_q && cyc_q == `CYC_END && !wr_pec_fail_in && !wr_valid_in
     && !cmd_valid_in) |=> buf_q[$past(lo_idx_w)][7:4] == `SPI_RB_PRE
    && buf_q[$past(hi_idx_w)][3:0] == `SPI_RB_POST)
    else $error("spi readback codes wrong");

  xfer_end_a: assert property (@(posedge link_clock_in) disable iff (lrst_w)
    (xfer_q && link_frame_in && !cmd_valid_in && grp_q == `MB_LAST_GROUP
     && cyc_q == `CYC_END) |=> !xfer_q) else $error("transfer overran");

  wd_release_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (req_q && clock_en_in) |=> oe_n_q == 3'h7)
    else $error("pins held during reset request");

  link_clear_a: assert property (@(posedge link_clock_in)
    lrst_w |=> lvl_q == 3'h7 && !xfer_q && buf_q[2] == `MB_RESET_BYTE)
    else $error("link state not cleared");

endmodule // gpio_i2c_spi_master_bridge

`default_nettype wire

// file: verif/spi_slave_model.sv
// SPI slave model on the wired select, data and clock lines.
// Assumes pull-ups on all three lines, so each idle line reads high.
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
  input  wire logic       sel_oe_n_in,  // Select pulled low by master
  input  wire logic       dat_oe_n_in,  // Data pulled low by master
  input  wire logic       clk_oe_n_in,  // Clock pulled low by master
  input  wire logic [7:0] tx_byte_in,   // Byte returned to the master
  output logic            dat_level_out // Wired data level
);
  logic sd_q = 1'b1; // Own data drive, 1 = released
  int   idx_q = -1;  // Next bit to present
  // Each select fall restarts the byte
  always @(negedge sel_oe_n_in) idx_q = 7;
  // New bit after each clock fall, MSB first
  always @(negedge clk_oe_n_in) begin
    sd_q = (!sel_oe_n_in && idx_q >= 0) ? tx_byte_in[idx_q] : 1'b1;
    idx_q = idx_q - 1;
  end
  // Let go when deselected, pull-up wins
  always @(posedge sel_oe_n_in) sd_q = 1'b1;
  assign dat_level_out = dat_oe_n_in & sd_q; // Open drain
endmodule // spi_slave_model
`default_nettype wire

// file: verif/test_gpio_i2c_spi_master_bridge.sv
// Testbench: buffer access, check fail, thermal, SPI run, watchdog.
// Assumes the slave model and the design compile first.
`timescale 1ns/1ps
`default_nettype none
module test_gpio_i2c_spi_master_bridge;
  logic       clock_in = 1'b0, link_clk = 1'b0, rstn = 1'b0, hot = 1'b0;
  logic       frame = 1'b0, cmd_v = 1'b0, wr_v = 1'b0, pec_bad = 1'b0, rd_go = 1'b0;
  gpio_master_pkg::cmd_e cmd = gpio_master_pkg::CMD_NONE;
  logic [7:0] wr_d = 8'h00, s_byte = 8'h00, rd_d;
  logic [2:0] rd_i = 3'h0;
  logic       busy, oe2, oe3, oe4, dat, lo2, lo3, lo4;
  logic [7:0] buf_v [6], ff6 [6] = '{default: 8'hff}, exp_q [$];
  int         n_mismatch = 0, comparisons = 0;
  // Core clock 100 MHz, link clock 80 ns
  initial forever #5 clock_in = ~clock_in;
  initial forever #40 link_clk = ~link_clk;
  gpio_i2c_spi_master_bridge #(.WDOG_CYCLES(2000)) gpio_i2c_spi_master_bridge_i (
    .clock_in(clock_in), .rstn_in(rstn), .clock_en_in(1'b1), .thermal_shutdown_in(hot),
    .link_clock_in(link_clk), .link_frame_in(frame), .cmd_valid_in(cmd_v), .cmd_in(cmd),
    .wr_valid_in(wr_v), .wr_data_in(wr_d), .wr_pec_fail_in(pec_bad), .rd_index_in(rd_i),
    .rd_data_out(rd_d), .xfer_busy_out(busy), .io_line_three_in(dat),
    .io_line_two_out(lo2), .io_line_two_oe_n_out(oe2), .io_line_three_out(lo3),
    .io_line_three_oe_n_out(oe3), .io_line_four_out(lo4), .io_line_four_oe_n_out(oe4));
  spi_slave_model spi_slave_model_i (.sel_oe_n_in(oe2), .dat_oe_n_in(oe3),
    .clk_oe_n_in(oe4), .tx_byte_in(s_byte), .dat_level_out(dat));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmd_go(input gpio_master_pkg::cmd_e c);
    @(negedge link_clk);
    cmd_v = 1'b1;
    cmd = c;
    @(negedge link_clk);
    cmd_v = 1'b0;
  endtask
  // Six bytes back to back, then an optional check failure
  task automatic wr_buf(input logic bad);
    cmd_go(gpio_master_pkg::CMD_WRITE_BUF);
    for (int i = 0; i < 6; i++) begin
      wr_v = 1'b1;
      wr_d = buf_v[i];
      @(negedge link_clk);
    end
    wr_v = 1'b0;
    pec_bad = bad;
    @(negedge link_clk);
    pec_bad = 1'b0;
  endtask
  // Notes each expected byte; the monitor compares it
  task automatic rd_buf(input logic [7:0] e [6]);
    for (int i = 0; i < 6; i++) begin
      @(negedge link_clk);
      rd_i = 3'(i);
      rd_go = 1'b1;
      exp_q.push_back(e[i]);
    end
    @(negedge link_clk);
    rd_go = 1'b0;
  endtask
  // Read data lands one link edge after the index
  always @(posedge link_clk) begin
    #1;
    if (rd_go && exp_q.size() > 0) check(rd_d, exp_q.pop_front());
  end
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(67));
    // Short reset; the held link request clears the link side afterwards
    repeat (3) @(negedge clock_in);
    rstn = 1'b1;
    repeat (8) @(negedge link_clk);
    rd_buf(ff6);
    check({5'h0, oe2, oe3, oe4}, 8'h07);
    check({5'h0, lo2, lo3, lo4}, 8'h00);
    foreach (buf_v[i]) buf_v[i] = 8'($urandom);
    wr_buf(1'b0);
    rd_buf(buf_v);
    wr_buf(1'b1);
    rd_buf(ff6);
    wr_buf(1'b0);
    @(negedge clock_in);
    hot = 1'b1;
    repeat (5) @(negedge clock_in);
    hot = 1'b0;
    repeat (8) @(negedge link_clk);
    rd_buf(ff6);
    // Select low, edge then raise, then a no-transmit group
    s_byte = 8'($urandom);
    buf_v = '{8'h8f, 8'hf0, 8'haf, 8'hf9, {4'hf, 4'($urandom)}, 8'($urandom)};
    wr_buf(1'b0);
    frame = 1'b1;
    cmd_go(gpio_master_pkg::CMD_START_XFER);
    repeat (12) @(negedge link_clk);
    check({7'h0, oe2}, 8'h00);
    check({7'h0, busy}, 8'h01);
    repeat (70) @(negedge link_clk);
    check({7'h0, busy}, 8'h00);
    frame = 1'b0;
    check({5'h0, oe2, oe3, oe4}, 8'h07);
    rd_buf('{{4'h7, s_byte[7:4]}, {s_byte[3:0], 4'hf}, {4'h7, s_byte[7:4]},
             {s_byte[3:0], 4'hf}, buf_v[4], buf_v[5]});
    // I2C: START with master ACK, blank with NACK, then a STOP group
    s_byte = 8'($urandom);
    buf_v = '{{4'h6, s_byte[7:4]}, {s_byte[3:0], 4'h0}, {4'h0, s_byte[3:0]},
              {s_byte[7:4], 4'h8}, {4'h1, 4'($urandom)}, 8'($urandom)};
    wr_buf(1'b0);
    frame = 1'b1;
    cmd_go(gpio_master_pkg::CMD_START_XFER);
    repeat (80) @(negedge link_clk);
    check({7'h0, busy}, 8'h00);
    frame = 1'b0;
    rd_buf('{{4'h6, s_byte[7:4]}, {s_byte[3:0], 4'h0}, {4'h0, s_byte[3:0]},
             {s_byte[7:4], 4'hf}, buf_v[4], buf_v[5]});
    repeat (3000) @(negedge clock_in);
    rd_buf(ff6);
    test_done;
  end
  // Hang guard, well past the expected run length
  initial begin
    #500us;
    n_mismatch++;
    test_done;
  end
endmodule // test_gpio_i2c_spi_master_bridge
`default_nettype wire
